// >>> inc/cpuod_pkg.sv
// Shared constants, encodings and types of the instruction decoder
package cpuod_pkg;

   // Single, leading and suffix opcode bytes
   localparam logic [7:0] OPC_COPY_TO_SEG = 8'h8e;
   localparam logic [7:0] OPC_COPY_FROM_SEG = 8'h8c;
   localparam logic [7:0] OPC_TABLE_LOOKUP = 8'hd7;
   localparam logic [7:0] OPC_EA_LOAD = 8'h8d;
   localparam logic [7:0] OPC_PTR_DS = 8'hc5;
   localparam logic [7:0] OPC_PTR_ES = 8'hc4;
   localparam logic [7:0] OPC_FLAGS_TO_AH = 8'h9f;
   localparam logic [7:0] OPC_AH_TO_FLAGS = 8'h9e;
   localparam logic [7:0] OPC_ASCII_ADD = 8'h37;
   localparam logic [7:0] OPC_DECIMAL_ADD = 8'h27;
   localparam logic [7:0] OPC_ASCII_SUB = 8'h3f;
   localparam logic [7:0] OPC_DECIMAL_SUB = 8'h2f;
   localparam logic [7:0] OPC_ASCII_MUL = 8'hd4;
   localparam logic [7:0] OPC_ASCII_DIV = 8'hd5;
   localparam logic [7:0] OPC_ASCII_SUFFIX = 8'h0a;
   localparam logic [7:0] OPC_BYTE_EXTEND = 8'h98;
   localparam logic [7:0] OPC_WORD_EXTEND = 8'h99;

   // Patterns matched on the upper bits of the first byte
   localparam logic [5:0] PAT_ADD_CARRY = 6'h04;
   localparam logic [5:0] PAT_SUBTRACT = 6'h0a;
   localparam logic [5:0] PAT_BORROW_REG = 6'h06;
   localparam logic [5:0] PAT_IMM_GROUP = 6'h20;
   localparam logic [6:0] PAT_BORROW_ACC = 7'h0e;
   localparam logic [6:0] PAT_UNARY_GROUP = 7'h7b;
   localparam logic [5:0] PAT_SHIFT_GROUP = 6'h34;

   // Middle field of the addressing byte
   localparam logic [2:0] FLD_IMM_BORROW = 3'h3;
   localparam logic [2:0] FLD_TEST = 3'h0;
   localparam logic [2:0] FLD_INVERT = 3'h2;
   localparam logic [2:0] FLD_SIGN_FLIP = 3'h3;
   localparam logic [2:0] FLD_MUL = 3'h4;
   localparam logic [2:0] FLD_SIGNED_PRODUCT_OP = 3'h5;
   localparam logic [2:0] FLD_DIV = 3'h6;
   localparam logic [2:0] FLD_SIGNED_QUOTIENT_OP = 3'h7;
   localparam logic [2:0] FLD_ROL = 3'h0;
   localparam logic [2:0] FLD_ROR = 3'h1;
   localparam logic [2:0] FLD_RCL = 3'h2;
   localparam logic [2:0] FLD_SHL = 3'h4;
   localparam logic [2:0] FLD_SHR = 3'h5;
   localparam logic [2:0] FLD_SAR = 3'h7;

   // Addressing byte layout and opcode bit positions
   localparam int MOD_HI = 7;
   localparam int MOD_LO = 6;
   localparam int REG_HI = 5;
   localparam int REG_LO = 3;
   localparam int RM_HI = 2;
   localparam int RM_LO = 0;
   localparam int BIT_W = 0;
   localparam int BIT_D = 1;
   localparam int BIT_S = 1;
   localparam int BIT_V = 1;
   localparam logic [1:0] MOD_DISP8 = 2'h1;
   localparam logic [1:0] MOD_DISP16 = 2'h2;
   localparam logic [1:0] MOD_NODISP = 2'h0;
   localparam logic [2:0] RM_DIRECT = 3'h6;

   // Register map, byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_DECODED = 8'h08;
   localparam logic [7:0] ADDR_UNSUPPORTED = 8'h0c;
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_CLEAR = 1;
   localparam logic CTRL_ENABLE_RST = 1'b1;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;

   // Instruction groups that need the addressing byte to resolve
   localparam logic [1:0] GRP_NONE = 2'h0;
   localparam logic [1:0] GRP_UNARY = 2'h1;
   localparam logic [1:0] GRP_SHIFT = 2'h2;
   localparam logic [1:0] GRP_IMM = 2'h3;

   typedef enum logic [5:0] {
      OP_NONE, OP_COPY_TO_SEG, OP_COPY_FROM_SEG, OP_TABLE_LOOKUP_BYTE,
      OP_EFFECTIVE_ADDRESS_LOAD, OP_POINTER_LOAD_DATA_SEGMENT,
      OP_POINTER_LOAD_EXTRA_SEGMENT, OP_FLAGS_TO_HIGH_ACC, OP_HIGH_ACC_TO_FLAGS,
      OP_ADD_WITH_CARRY, OP_SUBTRACT, OP_DIFFERENCE_WITH_BORROW,
      OP_ASCII_ADD_FIXUP, OP_DECIMAL_ADD_FIXUP, OP_ASCII_SUBTRACT_FIXUP,
      OP_DECIMAL_SUBTRACT_FIXUP, OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT,
      OP_UNSIGNED_QUOTIENT, OP_SIGNED_QUOTIENT, OP_INVERT, OP_SIGN_FLIP,
      OP_ASCII_MULTIPLY_FIXUP, OP_ASCII_DIVIDE_FIXUP, OP_BYTE_TO_WORD_EXTEND,
      OP_WORD_TO_DOUBLE_EXTEND, OP_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT,
      OP_ARITHMETIC_RIGHT_SHIFT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT,
      OP_CARRY_ROTATE_LEFT, OP_UNSUPPORTED
   } cpuod_op_e;

endpackage

// >>> src/cpuod_first_byte.sv
// Combinational classification of an instruction's first byte
`timescale 1ns/1ns
`default_nettype none
module cpuod_first_byte (
   input wire logic [7:0] opc,
   output cpuod_pkg::cpuod_op_e op,
   output logic [1:0] grp,
   output logic has_modrm,
   output logic needs_suffix,
   output logic [1:0] imm_bytes
);
   always_comb begin
      op = cpuod_pkg::OP_UNSUPPORTED;
      grp = cpuod_pkg::GRP_NONE;
      has_modrm = 1'b0;
      needs_suffix = 1'b0;
      imm_bytes = 2'h0;
      case (opc)
         cpuod_pkg::OPC_COPY_TO_SEG: begin
            op = cpuod_pkg::OP_COPY_TO_SEG; // [RQ1]
            has_modrm = 1'b1;
         end
         cpuod_pkg::OPC_COPY_FROM_SEG: begin
            op = cpuod_pkg::OP_COPY_FROM_SEG; // [RQ2]
            has_modrm = 1'b1;
         end
         cpuod_pkg::OPC_TABLE_LOOKUP: op = cpuod_pkg::OP_TABLE_LOOKUP_BYTE; // [RQ3]
         cpuod_pkg::OPC_EA_LOAD: begin
            op = cpuod_pkg::OP_EFFECTIVE_ADDRESS_LOAD; // [RQ4]
            has_modrm = 1'b1;
         end
         cpuod_pkg::OPC_PTR_DS: begin
            op = cpuod_pkg::OP_POINTER_LOAD_DATA_SEGMENT; // [RQ5]
            has_modrm = 1'b1;
         end
         cpuod_pkg::OPC_PTR_ES: begin
            op = cpuod_pkg::OP_POINTER_LOAD_EXTRA_SEGMENT; // [RQ5]
            has_modrm = 1'b1;
         end
         cpuod_pkg::OPC_FLAGS_TO_AH: op = cpuod_pkg::OP_FLAGS_TO_HIGH_ACC; // [RQ6]
         cpuod_pkg::OPC_AH_TO_FLAGS: op = cpuod_pkg::OP_HIGH_ACC_TO_FLAGS; // [RQ6]
         cpuod_pkg::OPC_ASCII_ADD: op = cpuod_pkg::OP_ASCII_ADD_FIXUP; // [RQ10]
         cpuod_pkg::OPC_DECIMAL_ADD: op = cpuod_pkg::OP_DECIMAL_ADD_FIXUP; // [RQ10]
         cpuod_pkg::OPC_ASCII_SUB: op = cpuod_pkg::OP_ASCII_SUBTRACT_FIXUP; // [RQ11]
         cpuod_pkg::OPC_DECIMAL_SUB: op = cpuod_pkg::OP_DECIMAL_SUBTRACT_FIXUP; // [RQ11]
         cpuod_pkg::OPC_ASCII_MUL: begin
            op = cpuod_pkg::OP_ASCII_MULTIPLY_FIXUP; // [RQ14]
            needs_suffix = 1'b1;
         end
         cpuod_pkg::OPC_ASCII_DIV: begin
            op = cpuod_pkg::OP_ASCII_DIVIDE_FIXUP; // [RQ15]
            needs_suffix = 1'b1;
         end
         cpuod_pkg::OPC_BYTE_EXTEND: op = cpuod_pkg::OP_BYTE_TO_WORD_EXTEND; // [RQ16]
         cpuod_pkg::OPC_WORD_EXTEND: op = cpuod_pkg::OP_WORD_TO_DOUBLE_EXTEND; // [RQ16]
         default: begin
            if (opc[7:2] == cpuod_pkg::PAT_ADD_CARRY) begin
               op = cpuod_pkg::OP_ADD_WITH_CARRY; // [RQ7]
               has_modrm = 1'b1;
            end else if (opc[7:2] == cpuod_pkg::PAT_SUBTRACT) begin
               op = cpuod_pkg::OP_SUBTRACT; // [RQ8]
               has_modrm = 1'b1;
            end else if (opc[7:2] == cpuod_pkg::PAT_BORROW_REG) begin
               op = cpuod_pkg::OP_DIFFERENCE_WITH_BORROW; // [RQ9]
               has_modrm = 1'b1;
            end else if (opc[7:1] == cpuod_pkg::PAT_BORROW_ACC) begin
               op = cpuod_pkg::OP_DIFFERENCE_WITH_BORROW; // [RQ9]
               imm_bytes = opc[cpuod_pkg::BIT_W] ? 2'h2 : 2'h1; // [RQ20]
            end else if (opc[7:2] == cpuod_pkg::PAT_IMM_GROUP) begin
               grp = cpuod_pkg::GRP_IMM; // [RQ9]
               has_modrm = 1'b1;
               // Sign-extended form carries a single immediate byte
               imm_bytes = (opc[cpuod_pkg::BIT_W] && !opc[cpuod_pkg::BIT_S]) ? 2'h2 : 2'h1;
            end else if (opc[7:1] == cpuod_pkg::PAT_UNARY_GROUP) begin
               grp = cpuod_pkg::GRP_UNARY; // [RQ12] [RQ13]
               has_modrm = 1'b1;
            end else if (opc[7:2] == cpuod_pkg::PAT_SHIFT_GROUP) begin
               grp = cpuod_pkg::GRP_SHIFT; // [RQ17]
               has_modrm = 1'b1;
            end
         end
      endcase
   end
endmodule // cpuod_first_byte
`default_nettype wire

// >>> src/cpuod_decoder.sv
// Instruction byte stream decoder with an AHB-Lite control and status slave
// What this block does
// RQ1 - Byte 8e plus addressing byte: copy into segment
// RQ2 - Byte 8c plus addressing byte: copy from segment
// RQ3 - Single byte d7 is table lookup
// RQ4 - Byte 8d loads effective address into register
// RQ5 - Bytes c5/c4 load pointer with data/extra segment
// RQ6 - Bytes 9f/9e move flags and high accumulator
// RQ7 - Pattern 000100dw is add with carry
// RQ8 - Pattern 001010dw is subtract, d picks destination
// RQ9 - Borrow subtract: register, immediate group 011, accumulator
// RQ10 - Bytes 37/27 are add fixups, no operands
// RQ11 - Bytes 3f/2f are subtract fixups
// RQ12 - Unary group fields 100/101 select multiplies
// RQ13 - Unary fields 110/111 divide, 010 invert, 011 negate
// RQ14 - Sequence d4 0a is multiply fixup
// RQ15 - Sequence d5 0a is divide fixup
// RQ16 - Bytes 98/99 are sign extensions
// RQ17 - Shift group field 100 left, 101 logical right
// RQ18 - Shift group field 111 arithmetic right
// RQ19 - Shift fields 000/001/010 rotate left/right/carry-left
// RQ20 - Width bit one: word operands, two-byte immediates; byte 83 (sign bit set) still takes a single immediate byte
// RQ21 - Count bit zero: count one; one: count register
//
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module cpuod_decoder #(
   parameter int ADDR_W = 32,
   parameter int DATA_W = 32
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [DATA_W-1:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [DATA_W-1:0] hrdata,
   output logic hresp,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   output logic byte_ready,
   output logic trail_valid,
   output logic [7:0] trail_data,
   output logic op_valid,
   output cpuod_pkg::cpuod_op_e op_kind,
   output logic op_wide,
   output logic op_to_reg,
   output logic op_count_from_reg,
   output logic [1:0] op_seg_sel,
   output logic [1:0] op_mod,
   output logic [2:0] op_reg,
   output logic [2:0] op_rm,
   output logic [1:0] op_disp_bytes,
   output logic [1:0] op_imm_bytes
);

   typedef enum logic [1:0] {ST_OPCODE, ST_MODRM, ST_SUFFIX, ST_TRAIL} cpuod_state_e;

   // Displacement bytes that follow an addressing byte
   function automatic logic [1:0] disp_len(input logic [1:0] md, input logic [2:0] rm);
      logic [1:0] n;
      n = 2'h0;
      if (md == cpuod_pkg::MOD_DISP8) begin
         n = 2'h1;
      end else if (md == cpuod_pkg::MOD_DISP16) begin
         n = 2'h2;
      end else if (md == cpuod_pkg::MOD_NODISP && rm == cpuod_pkg::RM_DIRECT) begin
         n = 2'h2;
      end
      return n;
   endfunction

   // Operation of a group opcode from the middle field
   function automatic cpuod_pkg::cpuod_op_e resolve(input logic [1:0] grp,
         input cpuod_pkg::cpuod_op_e first, input logic [2:0] fld);
      cpuod_pkg::cpuod_op_e r;
      r = first;
      case (grp)
         cpuod_pkg::GRP_UNARY: begin
            case (fld)
               cpuod_pkg::FLD_MUL: r = cpuod_pkg::OP_UNSIGNED_PRODUCT; // [RQ12]
               cpuod_pkg::FLD_SIGNED_PRODUCT_OP: r = cpuod_pkg::OP_SIGNED_PRODUCT; // [RQ12]
               cpuod_pkg::FLD_DIV: r = cpuod_pkg::OP_UNSIGNED_QUOTIENT; // [RQ13]
               cpuod_pkg::FLD_SIGNED_QUOTIENT_OP: r = cpuod_pkg::OP_SIGNED_QUOTIENT; // [RQ13]
               cpuod_pkg::FLD_INVERT: r = cpuod_pkg::OP_INVERT; // [RQ13]
               cpuod_pkg::FLD_SIGN_FLIP: r = cpuod_pkg::OP_SIGN_FLIP; // [RQ13]
               default: r = cpuod_pkg::OP_UNSUPPORTED;
            endcase
         end
         cpuod_pkg::GRP_SHIFT: begin
            case (fld)
               cpuod_pkg::FLD_SHL: r = cpuod_pkg::OP_LEFT_SHIFT; // [RQ17]
               cpuod_pkg::FLD_SHR: r = cpuod_pkg::OP_LOGICAL_RIGHT_SHIFT; // [RQ17]
               cpuod_pkg::FLD_SAR: r = cpuod_pkg::OP_ARITHMETIC_RIGHT_SHIFT; // [RQ18]
               cpuod_pkg::FLD_ROL: r = cpuod_pkg::OP_ROTATE_LEFT; // [RQ19]
               cpuod_pkg::FLD_ROR: r = cpuod_pkg::OP_ROTATE_RIGHT; // [RQ19]
               cpuod_pkg::FLD_RCL: r = cpuod_pkg::OP_CARRY_ROTATE_LEFT; // [RQ19]
               default: r = cpuod_pkg::OP_UNSUPPORTED;
            endcase
         end
         cpuod_pkg::GRP_IMM: begin
            if (fld == cpuod_pkg::FLD_IMM_BORROW) begin
               r = cpuod_pkg::OP_DIFFERENCE_WITH_BORROW; // [RQ9]
            end else begin
               r = cpuod_pkg::OP_UNSUPPORTED;
            end
         end
         default: r = first;
      endcase
      return r;
   endfunction

   cpuod_state_e state;
   cpuod_pkg::cpuod_op_e cls_op;
   cpuod_pkg::cpuod_op_e next_op;
   logic [1:0] cls_grp;
   logic cls_modrm;
   logic cls_suffix;
   logic [1:0] cls_imm;
   logic [1:0] cur_grp;
   logic [2:0] trail_left;
   logic [1:0] next_imm;
   logic [1:0] next_disp;
   logic [2:0] byte_fld;
   logic take;
   logic ctrl_enable;
   logic clear_counts;
   logic wr_pend;
   logic [7:0] wr_addr;
   logic addr_phase;
   logic [31:0] decoded_count;
   logic [31:0] unsupported_count;

   assign take = byte_valid && byte_ready;
   assign byte_fld = byte_data[cpuod_pkg::REG_HI:cpuod_pkg::REG_LO];
   assign addr_phase = hsel && hready && (htrans == cpuod_pkg::HTRANS_NONSEQ);

   cpuod_first_byte u_first_byte (
      .opc(byte_data),
      .op(cls_op),
      .grp(cls_grp),
      .has_modrm(cls_modrm),
      .needs_suffix(cls_suffix),
      .imm_bytes(cls_imm)
   );

   // Operation and trailing counts from the addressing byte
   always_comb begin
      next_op = resolve(cur_grp, op_kind, byte_fld);
      next_disp = disp_len(byte_data[cpuod_pkg::MOD_HI:cpuod_pkg::MOD_LO],
                           byte_data[cpuod_pkg::RM_HI:cpuod_pkg::RM_LO]);
      next_imm = op_imm_bytes;
      // Flag-test form of the unary group still carries an immediate
      if (cur_grp == cpuod_pkg::GRP_UNARY && byte_fld == cpuod_pkg::FLD_TEST) begin
         next_imm = op_wide ? 2'h2 : 2'h1; // [RQ20]
      end
   end

   // Decode sequencer; fields held until the next opcode byte
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= ST_OPCODE;
         op_valid <= 1'b0;
         op_kind <= cpuod_pkg::OP_NONE;
         op_wide <= 1'b0;
         op_to_reg <= 1'b0;
         op_count_from_reg <= 1'b0;
         op_seg_sel <= 2'h0;
         op_mod <= 2'h0;
         op_reg <= 3'h0;
         op_rm <= 3'h0;
         op_disp_bytes <= 2'h0;
         op_imm_bytes <= 2'h0;
         cur_grp <= cpuod_pkg::GRP_NONE;
         trail_left <= 3'h0;
      end else begin
         op_valid <= 1'b0;
         if (take) begin
            case (state)
               ST_OPCODE: begin
                  op_kind <= cls_op;
                  cur_grp <= cls_grp;
                  op_wide <= byte_data[cpuod_pkg::BIT_W]; // [RQ20]
                  op_to_reg <= byte_data[cpuod_pkg::BIT_D]; // [RQ7] [RQ8]
                  op_count_from_reg <= (cls_grp == cpuod_pkg::GRP_SHIFT) &&
                                       byte_data[cpuod_pkg::BIT_V]; // [RQ21]
                  op_imm_bytes <= cls_imm;
                  op_disp_bytes <= 2'h0;
                  op_mod <= 2'h0;
                  op_reg <= 3'h0;
                  op_rm <= 3'h0;
                  op_seg_sel <= 2'h0;
                  if (cls_modrm) begin
                     state <= ST_MODRM;
                  end else if (cls_suffix) begin
                     state <= ST_SUFFIX; // [RQ14] [RQ15]
                  end else if (cls_imm != 2'h0) begin
                     trail_left <= {1'b0, cls_imm};
                     state <= ST_TRAIL;
                  end else begin
                     op_valid <= 1'b1; // [RQ3] [RQ6] [RQ10] [RQ11] [RQ16]
                  end
               end
               ST_MODRM: begin
                  op_kind <= next_op;
                  op_mod <= byte_data[cpuod_pkg::MOD_HI:cpuod_pkg::MOD_LO];
                  op_reg <= byte_fld;
                  op_rm <= byte_data[cpuod_pkg::RM_HI:cpuod_pkg::RM_LO];
                  // Segment number sits in the two low bits of the middle field
                  op_seg_sel <= byte_data[cpuod_pkg::REG_HI-1:cpuod_pkg::REG_LO]; // [RQ1] [RQ2]
                  op_disp_bytes <= next_disp;
                  op_imm_bytes <= next_imm;
                  // Up to four trailing bytes, so the sum needs three bits
                  if (next_disp == 2'h0 && next_imm == 2'h0) begin
                     op_valid <= 1'b1;
                     state <= ST_OPCODE;
                  end else begin
                     trail_left <= {1'b0, next_disp} + {1'b0, next_imm};
                     state <= ST_TRAIL;
                  end
               end
               ST_SUFFIX: begin
                  if (byte_data != cpuod_pkg::OPC_ASCII_SUFFIX) begin
                     op_kind <= cpuod_pkg::OP_UNSUPPORTED; // [RQ14] [RQ15]
                  end
                  op_valid <= 1'b1;
                  state <= ST_OPCODE;
               end
               ST_TRAIL: begin
                  trail_left <= trail_left - 3'h1;
                  if (trail_left == 3'h1) begin
                     op_valid <= 1'b1;
                     state <= ST_OPCODE;
                  end
               end
               default: state <= ST_OPCODE;
            endcase
         end
      end
   end

   // Trailing bytes pass straight to the datapath
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trail_valid <= 1'b0;
         trail_data <= 8'h00;
      end else begin
         trail_valid <= take && (state == ST_TRAIL);
         if (take && state == ST_TRAIL) begin
            trail_data <= byte_data;
         end
      end
   end

   // Stream flow: a disabled decoder stalls the prefetch queue
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         byte_ready <= 1'b0;
      end else begin
         byte_ready <= ctrl_enable;
      end
   end

   // Counters; an increment in the clearing cycle is kept
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         decoded_count <= '0;
         unsupported_count <= '0;
      end else begin
         if (clear_counts) begin
            decoded_count <= 32'(op_valid);
            unsupported_count <= 32'(op_valid &&
                                     op_kind == cpuod_pkg::OP_UNSUPPORTED);
         end else if (op_valid) begin
            decoded_count <= decoded_count + 32'h1;
            if (op_kind == cpuod_pkg::OP_UNSUPPORTED) begin
               unsupported_count <= unsupported_count + 32'h1;
            end
         end
      end
   end

   // Bus address phase capture; the slave never inserts wait states
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= cpuod_pkg::HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp <= cpuod_pkg::HRESP_OKAY;
         wr_pend <= addr_phase && hwrite;
         if (addr_phase) begin
            wr_addr <= haddr[7:0];
         end
      end
   end

   // Read data is latched at the address phase so it stands for the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (addr_phase && !hwrite) begin
         case (haddr[7:0])
            cpuod_pkg::ADDR_CTRL: hrdata <= DATA_W'(ctrl_enable);
            cpuod_pkg::ADDR_STATUS: hrdata <= DATA_W'({21'h0, state, op_wide,
                                                      op_kind, byte_ready, 1'b0});
            cpuod_pkg::ADDR_DECODED: hrdata <= DATA_W'(decoded_count);
            cpuod_pkg::ADDR_UNSUPPORTED: hrdata <= DATA_W'(unsupported_count);
            default: hrdata <= '0;
         endcase
      end
   end

   // Control write in the data phase; clear self-clears
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_enable <= cpuod_pkg::CTRL_ENABLE_RST;
         clear_counts <= 1'b0;
      end else begin
         clear_counts <= 1'b0;
         if (wr_pend && wr_addr == cpuod_pkg::ADDR_CTRL) begin
            ctrl_enable <= hwdata[cpuod_pkg::CTRL_ENABLE];
            clear_counts <= hwdata[cpuod_pkg::CTRL_CLEAR];
         end
      end
   end

endmodule // cpuod_decoder
`default_nettype wire

// >>> bench/cpuod_decoder_assertions.sv
// Decoder port checker
`timescale 1ns/1ns
`default_nettype none
module cpuod_decoder_checker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic byte_ready,
   input wire logic trail_valid,
   input wire logic [7:0] trail_data,
   input wire logic op_valid,
   input wire cpuod_pkg::cpuod_op_e op_kind
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_take;
      byte_valid && byte_ready;
   endsequence
   // An op ends on the byte taken just before
   property p_last(k, b);
      op_valid && op_kind == k |-> $past(byte_valid && byte_ready && byte_data == b);
   endproperty
   a_bus_ready: assert property (hreadyout)
      else $error("hreadyout low");
   a_op_after_take: assert property (op_valid |-> $past(byte_valid && byte_ready))
      else $error("op_valid without byte");
   a_trail_echo: assert property (s_take ##1 trail_valid |-> trail_data == $past(byte_data))
      else $error("trail_data wrong");
   a_lookup_last: assert property (p_last(cpuod_pkg::OP_TABLE_LOOKUP_BYTE, 8'hd7))
      else $error("bad lookup byte");
   a_flags_last: assert property (p_last(cpuod_pkg::OP_FLAGS_TO_HIGH_ACC, 8'h9f))
      else $error("bad flags byte");
   a_mul_fix_last: assert property (p_last(cpuod_pkg::OP_ASCII_MULTIPLY_FIXUP, 8'h0a))
      else $error("bad suffix");
   a_div_fix_last: assert property (p_last(cpuod_pkg::OP_ASCII_DIVIDE_FIXUP, 8'h0a))
      else $error("bad suffix");
   a_extend_last: assert property (p_last(cpuod_pkg::OP_BYTE_TO_WORD_EXTEND, 8'h98))
      else $error("bad extend byte");
endmodule // cpuod_decoder_checker
bind cpuod_decoder cpuod_decoder_checker u_cpuod_decoder_checker (.*);
`default_nettype wire

// >>> bench/cpuod_prefetch.sv
// Prefetch queue model
`timescale 1ns/1ns
`default_nettype none
module cpuod_prefetch (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic byte_ready,
   input wire logic slow,
   output logic byte_valid,
   output logic [7:0] byte_data
);
   logic [7:0] q[$];
   logic gap;
   // Idle data inverted to expose unqualified reads
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         byte_valid <= 1'b0;
         byte_data <= 8'h00;
         gap <= 1'b0;
      end else if (!byte_valid || byte_ready) begin
         gap <= !gap;
         byte_valid <= 1'b0;
         byte_data <= ~byte_data;
         if (q.size() > 0 && (!slow || gap)) begin
            byte_valid <= 1'b1;
            byte_data <= q.pop_front();
         end
      end
   end
endmodule // cpuod_prefetch
`default_nettype wire

// >>> bench/cpuod_decoder_test.sv
// Decoder self-checking bench
`timescale 1ns/1ns
`default_nettype none
module cpuod_decoder_test;
   logic hclk, hresetn, hsel, hwrite, slow, hreadyout, hresp, byte_valid, byte_ready;
   logic trail_valid, op_valid, op_wide, op_to_reg, op_count_from_reg;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, op_seg_sel, op_imm_bytes;
   logic [2:0] hsize;
   logic [7:0] byte_data, trail_data;
   cpuod_pkg::cpuod_op_e op_kind;
   int n_fail = 0, checked = 0;
   cpuod_decoder u_cpuod_decoder (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .byte_valid, .byte_data,
      .byte_ready, .trail_valid, .trail_data, .op_valid, .op_kind, .op_wide, .op_to_reg,
      .op_count_from_reg, .op_seg_sel, .op_mod(), .op_reg(), .op_rm(), .op_disp_bytes(),
      .op_imm_bytes);
   cpuod_prefetch u_cpuod_prefetch (.hclk, .hresetn, .byte_ready, .slow, .byte_valid,
      .byte_data);
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   task automatic check(input string nm, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= cpuod_pkg::HTRANS_NONSEQ;
      haddr <= 32'(a);
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // Nonzero bytes queued low first
   task automatic run(input logic [31:0] b, input cpuod_pkg::cpuod_op_e k);
      int i;
      for (i = 0; i < 4; i++) if (b[8*i+:8] != 8'h00) u_cpuod_prefetch.q.push_back(b[8*i+:8]);
      i = 0;
      do @(negedge hclk); while (op_valid !== 1'b1 && ++i < 40);
      check("op_valid", op_valid, 1'b1);
      check("op_kind", op_kind, k);
      check("op_wide", op_wide, b[0]);
      check("op_count_from_reg", op_count_from_reg, b[7:2] == 6'h34 && b[1]);
   endtask
   task automatic give_verdict;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge hclk);
      n_fail++;
      give_verdict();
   end
   initial begin
      {hresetn, hsel, hwrite, slow, htrans, hsize, haddr, hwdata} = {6'h00, 3'h2, 64'h0};
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, cpuod_pkg::ADDR_CTRL, 32'h0);
      check("ctrl", rd, 32'h1);
      ahb(1'b0, 8'h10, 32'h0);
      check("unmapped", rd, 32'h0);
      run(32'hd88e, cpuod_pkg::OP_COPY_TO_SEG);
      check("op_seg_sel", op_seg_sel, 2'h3);
      run(32'hc88c, cpuod_pkg::OP_COPY_FROM_SEG);
      run(32'hd7, cpuod_pkg::OP_TABLE_LOOKUP_BYTE);
      run(32'h1234068d, cpuod_pkg::OP_EFFECTIVE_ADDRESS_LOAD);
      run(32'hc0c5, cpuod_pkg::OP_POINTER_LOAD_DATA_SEGMENT);
      run(32'hc0c4, cpuod_pkg::OP_POINTER_LOAD_EXTRA_SEGMENT);
      run(32'h9f, cpuod_pkg::OP_FLAGS_TO_HIGH_ACC);
      run(32'h9e, cpuod_pkg::OP_HIGH_ACC_TO_FLAGS);
      run(32'hc013, cpuod_pkg::OP_ADD_WITH_CARRY);
      check("op_to_reg", op_to_reg, 1'b1);
      run(32'hc028, cpuod_pkg::OP_SUBTRACT);
      check("op_to_reg", op_to_reg, 1'b0);
      run(32'hc01a, cpuod_pkg::OP_DIFFERENCE_WITH_BORROW);
      slow <= 1'b1;
      run(32'h34125883, cpuod_pkg::OP_DIFFERENCE_WITH_BORROW);
      check("op_imm_bytes", op_imm_bytes, 2'h1);
      run(32'h12341d, cpuod_pkg::OP_DIFFERENCE_WITH_BORROW);
      check("op_imm_bytes", op_imm_bytes, 2'h2);
      run(32'h37, cpuod_pkg::OP_ASCII_ADD_FIXUP);
      run(32'h27, cpuod_pkg::OP_DECIMAL_ADD_FIXUP);
      run(32'h3f, cpuod_pkg::OP_ASCII_SUBTRACT_FIXUP);
      run(32'h2f, cpuod_pkg::OP_DECIMAL_SUBTRACT_FIXUP);
      run(32'he0f7, cpuod_pkg::OP_UNSIGNED_PRODUCT);
      run(32'he8f6, cpuod_pkg::OP_SIGNED_PRODUCT);
      run(32'hf0f7, cpuod_pkg::OP_UNSIGNED_QUOTIENT);
      run(32'hf8f7, cpuod_pkg::OP_SIGNED_QUOTIENT);
      run(32'hd0f7, cpuod_pkg::OP_INVERT);
      run(32'hd8f7, cpuod_pkg::OP_SIGN_FLIP);
      run(32'h0ad4, cpuod_pkg::OP_ASCII_MULTIPLY_FIXUP);
      run(32'h0ad5, cpuod_pkg::OP_ASCII_DIVIDE_FIXUP);
      run(32'h0bd4, cpuod_pkg::OP_UNSUPPORTED);
      slow <= 1'b0;
      run(32'h98, cpuod_pkg::OP_BYTE_TO_WORD_EXTEND);
      run(32'h99, cpuod_pkg::OP_WORD_TO_DOUBLE_EXTEND);
      run(32'he0d1, cpuod_pkg::OP_LEFT_SHIFT);
      run(32'he8d3, cpuod_pkg::OP_LOGICAL_RIGHT_SHIFT);
      run(32'hf8d0, cpuod_pkg::OP_ARITHMETIC_RIGHT_SHIFT);
      run(32'hc0d1, cpuod_pkg::OP_ROTATE_LEFT);
      run(32'hc8d1, cpuod_pkg::OP_ROTATE_RIGHT);
      run(32'hd0d1, cpuod_pkg::OP_CARRY_ROTATE_LEFT);
      run(32'hc8f7, cpuod_pkg::OP_UNSUPPORTED);
      ahb(1'b0, cpuod_pkg::ADDR_UNSUPPORTED, 32'h0);
      check("unsupported count", rd, 32'h2);
      ahb(1'b1, cpuod_pkg::ADDR_CTRL, 32'h0);
      repeat (3) @(posedge hclk);
      check("byte_ready", byte_ready, 1'b0);
      u_cpuod_prefetch.q.push_back(8'h98);
      repeat (4) @(posedge hclk);
      check("byte_valid", byte_valid, 1'b1);
      ahb(1'b1, cpuod_pkg::ADDR_CTRL, 32'h1);
      run(32'h0, cpuod_pkg::OP_BYTE_TO_WORD_EXTEND);
      give_verdict();
   end
endmodule // cpuod_decoder_test
`default_nettype wire
